// *** logic/pfm_defines.svh ***
// Operation
// R1 - chip select input from three candidate pads
// R2 - serial clock input from four candidate pads
// R3 - spi master drives clock on every candidate; the code drives it only on lines A1 and A6 when set to clock, not on C6 or D2
// R4 - serial data input from four candidate pads
// R5 - second source register upper nibble reads zero
// R6 - interrupt 1 from line A7 or A4
// R7 - interrupt 0 from line B0 or A1
// R8 - line A2 serial data or gpio
// R9 - line A1 gpio, clock, timer inverted, analog
// R10 - line A0 transmit output or gpio
// R11 - line A7 gpio, segment 2, transmit, analog
// R12 - line A6 gpio, segment 1, clock, analog
// R13 - line A5 gpio, segment 0, data, analog
// R14 - line A4 reference voltage or gpio
// R15 - line B0 gpio, segment 3, select, analog
// R16 - lines B2 B4 B5 segments or gpio
// R17 - line B7 transmit, analog or gpio
// R18 - line B6 timer output, analog or gpio
// R19 - lines C0 to C3 commons or gpio
// R20 - peripheral output owns pad, else gpio
// R21 - peripheral input sees only its selected pad
`ifndef PFM_DEFINES_SVH
`define PFM_DEFINES_SVH

// ****************************************************************
// bus geometry and register map
// ****************************************************************
`define PFM_ADDR_W     12
`define PFM_DATA_W     32
`define PFM_REG_W      8
`define PFM_REG_COUNT  7
`define PFM_IDX_LSB    2
`define PFM_IDX_W      3
`define PFM_IDX_IN0    3'h0
`define PFM_IDX_IN1    3'h1
`define PFM_IDX_PAL    3'h2
`define PFM_IDX_PAH    3'h3
`define PFM_IDX_PBL    3'h4
`define PFM_IDX_PBH    3'h5
`define PFM_IDX_PCL    3'h6
`define PFM_REG_RST    8'h00
`define PFM_FULL_MASK  8'hff
`define PFM_IN1_MASK   8'h0f

// ****************************************************************
// field positions and codes
// ****************************************************************
`define PFM_STD_LSB    6
`define PFM_CS_LSB     4
`define PFM_CLK_LSB    2
`define PFM_DAT_LSB    0
`define PFM_EXTERNAL_INTERRUPT_1_LSB   2
`define PFM_EXTERNAL_INTERRUPT_0_LSB   0
`define PFM_CODE_W     2
`define PFM_CODE_GPIO  2'h0
`define PFM_CODE_ALT1  2'h1
`define PFM_CODE_ALT2  2'h2
`define PFM_CODE_ALT3  2'h3
`define PFM_PADS       32
`define PFM_SEGS       9
`define PFM_COMS       4
`define PFM_ANA        8

`endif

// *** logic/pfm_pkg.sv ***
package pfm_pkg;

	typedef struct packed {
		logic [7:0] pd;
		logic [7:0] pc;
		logic [7:0] pb;
		logic [7:0] pa;
	} pfm_port_t;

	typedef struct packed {
		logic [7:0] portCLow;
		logic [7:0] portBHigh;
		logic [7:0] portBLow;
		logic [7:0] portAHigh;
		logic [7:0] portALow;
		logic [7:0] inSrc1;
		logic [7:0] inSrc0;
	} pfm_regs_t;

	typedef struct packed {
		logic serClkOut;
		logic txOut;
		logic txOe;
		logic dataOut;
		logic dataOe;
		logic chipSelOut;
		logic chipSelOe;
	} pfm_serial_t;

	typedef struct packed {
		logic chipSel;
		logic serClk;
		logic serData;
		logic extInterrupt0;
		logic extInterrupt1;
		logic timerClkIn;
		logic timerCapIn;
		logic stdCapIn;
	} pfm_periph_in_t;

endpackage

// *** logic/pfm_apb_regs.sv ***
`timescale 1ns/1ps
`include "pfm_defines.svh"
module pfm_apb_regs #(
	parameter int ADDR_W = `PFM_ADDR_W
) (
	input  wire logic                clock,
	input  wire logic                rstn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	output pfm_pkg::pfm_regs_t       regs
);
	import pfm_pkg::*;

	// ****************************************************************
	// decode
	// ****************************************************************
	localparam int RW = `PFM_REG_W;
	logic [RW-1:0]         regFile [`PFM_REG_COUNT];
	logic [RW-1:0]         rdTerm  [`PFM_REG_COUNT];
	logic [RW-1:0]         rdBus;
	wire  [`PFM_IDX_W-1:0] regIdx = paddr[`PFM_IDX_LSB +: `PFM_IDX_W];
	wire                   setup  = psel & ~penable;
	wire                   hit    = (paddr >> (`PFM_IDX_LSB + `PFM_IDX_W))
	                                == '0
	                                && paddr[`PFM_IDX_LSB-1:0] == '0
	                                && regIdx < `PFM_IDX_W'(`PFM_REG_COUNT);
	// only lane 0 carries data; a write without it is silently dropped
	wire                   wrEn   = psel & penable & pwrite & pready
	                                & hit & pstrb[0];

	genvar i;
	generate
		for (i = 0; i < `PFM_REG_COUNT; i++) begin : g_reg
			wire [RW-1:0] mask = (i == `PFM_IDX_IN1) ? `PFM_IN1_MASK
			                                         : `PFM_FULL_MASK;
			wire          sel  = regIdx == `PFM_IDX_W'(i);
			assign rdTerm[i] = sel ? regFile[i] : '0;
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					regFile[i] <= `PFM_REG_RST;
				end else if (wrEn && sel) begin
					regFile[i] <= pwdata[RW-1:0] & mask; // see R5
				end
			end
		end
	endgenerate

	always_comb begin
		rdBus = '0;
		for (int k = 0; k < `PFM_REG_COUNT; k++) begin
			rdBus = rdBus | rdTerm[k];
		end
	end

	// ****************************************************************
	// answer: one wait-free access phase after the setup cycle
	// ****************************************************************
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~hit;
			prdata  <= (setup & hit & ~pwrite) ? {{(32-RW){1'b0}}, rdBus}
			                                   : '0;
		end
	end

	assign regs.inSrc0    = regFile[`PFM_IDX_IN0];
	assign regs.inSrc1    = regFile[`PFM_IDX_IN1];
	assign regs.portALow  = regFile[`PFM_IDX_PAL];
	assign regs.portAHigh = regFile[`PFM_IDX_PAH];
	assign regs.portBLow  = regFile[`PFM_IDX_PBL];
	assign regs.portBHigh = regFile[`PFM_IDX_PBH];
	assign regs.portCLow  = regFile[`PFM_IDX_PCL];

	chk_in1_upper: assert property (@(posedge clock) disable iff (!rstn)
		regs.inSrc1[7:4] == 4'h0) // see R5
		else $error("upper nibble of second source register is set");
	chk_apb_answer: assert property (@(posedge clock) disable iff (!rstn)
		setup |=> pready && (pslverr == !$past(hit)))
		else $error("apb access phase not answered in one cycle");

endmodule

// *** logic/pfm_pin_mux.sv ***
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "pfm_defines.svh"
module pfm_pin_mux #(
	parameter int ADDR_W = `PFM_ADDR_W
) (
	input  wire logic                   clock,
	input  wire logic                   rstn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [ADDR_W-1:0]      paddr,
	input  wire logic [31:0]            pwdata,
	input  wire logic [3:0]             pstrb,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  pfm_pkg::pfm_port_t          padIn,
	input  pfm_pkg::pfm_port_t          gpioOut,
	input  pfm_pkg::pfm_port_t          gpioIsInput,
	input  wire logic                   serEnable,
	input  wire logic                   spiMaster,
	input  pfm_pkg::pfm_serial_t        serial,
	input  wire logic                   timerOut,
	input  wire logic [`PFM_SEGS-1:0]   lcdSeg,
	input  wire logic [`PFM_COMS-1:0]   lcdCom,
	output pfm_pkg::pfm_port_t          padOut,
	output pfm_pkg::pfm_port_t          padOe,
	output pfm_pkg::pfm_periph_in_t     periphIn,
	output logic      [`PFM_ANA-1:0]    analogSel,
	output logic                        vrefSel
);
	import pfm_pkg::*;

	// ****************************************************************
	// register file
	// ****************************************************************
	pfm_regs_t regs;

	pfm_apb_regs #(
		.ADDR_W (ADDR_W)
	) u_regs (
		.clock   (clock),
		.rstn    (rstn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pstrb   (pstrb),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.regs    (regs)
	);

	// ****************************************************************
	// pad input synchroniser
	// ****************************************************************
	pfm_port_t padMeta;
	pfm_port_t padSync;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			padMeta <= '0;
			padSync <= '0;
		end else begin
			padMeta <= padIn;
			padSync <= padMeta;
		end
	end

	// ****************************************************************
	// function fields, two bits per pad
	// ****************************************************************
	localparam int CW = `PFM_CODE_W;
	wire [2*8-1:0] funcWordA = {regs.portAHigh, regs.portALow};
	wire [2*8-1:0] funcWordB = {regs.portBHigh, regs.portBLow};
	wire [CW-1:0]  fA [8];
	wire [CW-1:0]  fB [8];
	wire [CW-1:0]  fC [4];

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_field
			assign fA[g] = funcWordA[CW*g +: CW];
			assign fB[g] = funcWordB[CW*g +: CW];
			if (g < `PFM_COMS) begin : g_fc
				assign fC[g] = regs.portCLow[CW*g +: CW];
			end
		end
	endgenerate

	wire [CW-1:0] srcStd  = regs.inSrc0[`PFM_STD_LSB +: CW];
	wire [CW-1:0] srcCs   = regs.inSrc0[`PFM_CS_LSB +: CW];
	wire [CW-1:0] srcClk  = regs.inSrc0[`PFM_CLK_LSB +: CW];
	wire [CW-1:0] srcDat  = regs.inSrc0[`PFM_DAT_LSB +: CW];
	wire [CW-1:0] srcInt1 = regs.inSrc1[`PFM_EXTERNAL_INTERRUPT_1_LSB +: CW];
	wire [CW-1:0] srcInt0 = regs.inSrc1[`PFM_EXTERNAL_INTERRUPT_0_LSB +: CW];

	// master clock goes out on any pad set to clock, whatever the source
	wire sckDrive = serEnable & spiMaster; // see R3

	// ****************************************************************
	// alternate function per pad
	// ****************************************************************
	// analog and reference selections claim the pad with no drive so
	// that neither gpio nor a peripheral can load the analog node
	pfm_port_t altSel;
	pfm_port_t altOut;
	pfm_port_t altOe;

	// line A0 see R10
	assign altSel.pa[0] = fA[0] == `PFM_CODE_ALT1;
	assign altOut.pa[0] = serial.txOut;
	assign altOe.pa[0]  = serial.txOe;
	// line A1 see R9
	assign altSel.pa[1] = fA[1] != `PFM_CODE_GPIO;
	assign altOut.pa[1] = (fA[1] == `PFM_CODE_ALT1) ? serial.serClkOut
	                    : (fA[1] == `PFM_CODE_ALT2) ? ~timerOut : 1'b0;
	assign altOe.pa[1]  = (fA[1] == `PFM_CODE_ALT1) ? sckDrive
	                    : (fA[1] == `PFM_CODE_ALT2);
	// line A2 see R8
	assign altSel.pa[2] = fA[2] == `PFM_CODE_ALT1;
	assign altOut.pa[2] = serial.dataOut;
	assign altOe.pa[2]  = serial.dataOe;
	// line A3 stays general purpose
	assign altSel.pa[3] = 1'b0;
	assign altOut.pa[3] = 1'b0;
	assign altOe.pa[3]  = 1'b0;
	// line A4 see R14
	assign altSel.pa[4] = fA[4] == `PFM_CODE_ALT2;
	assign altOut.pa[4] = 1'b0;
	assign altOe.pa[4]  = 1'b0;
	// line A5 see R13
	assign altSel.pa[5] = fA[5] != `PFM_CODE_GPIO;
	assign altOut.pa[5] = (fA[5] == `PFM_CODE_ALT1) ? lcdSeg[0]
	                    : (fA[5] == `PFM_CODE_ALT2) ? serial.dataOut : 1'b0;
	assign altOe.pa[5]  = (fA[5] == `PFM_CODE_ALT1)
	                    | ((fA[5] == `PFM_CODE_ALT2) & serial.dataOe);
	// line A6 see R12
	assign altSel.pa[6] = fA[6] != `PFM_CODE_GPIO;
	assign altOut.pa[6] = (fA[6] == `PFM_CODE_ALT1) ? lcdSeg[1]
	                    : (fA[6] == `PFM_CODE_ALT2) ? serial.serClkOut : 1'b0;
	assign altOe.pa[6]  = (fA[6] == `PFM_CODE_ALT1)
	                    | ((fA[6] == `PFM_CODE_ALT2) & sckDrive);
	// line A7 see R11
	assign altSel.pa[7] = fA[7] != `PFM_CODE_GPIO;
	assign altOut.pa[7] = (fA[7] == `PFM_CODE_ALT1) ? lcdSeg[2]
	                    : (fA[7] == `PFM_CODE_ALT2) ? serial.txOut : 1'b0;
	assign altOe.pa[7]  = (fA[7] == `PFM_CODE_ALT1)
	                    | ((fA[7] == `PFM_CODE_ALT2) & serial.txOe);

	// line B0 see R15
	assign altSel.pb[0] = fB[0] != `PFM_CODE_GPIO;
	assign altOut.pb[0] = (fB[0] == `PFM_CODE_ALT1) ? lcdSeg[3]
	                    : (fB[0] == `PFM_CODE_ALT2) ? serial.chipSelOut
	                    : 1'b0;
	assign altOe.pb[0]  = (fB[0] == `PFM_CODE_ALT1)
	                    | ((fB[0] == `PFM_CODE_ALT2) & serial.chipSelOe);
	// lines B1 and B3 stay general purpose
	assign altSel.pb[1] = 1'b0;
	assign altOut.pb[1] = 1'b0;
	assign altOe.pb[1]  = 1'b0;
	assign altSel.pb[3] = 1'b0;
	assign altOut.pb[3] = 1'b0;
	assign altOe.pb[3]  = 1'b0;
	// lines B2, B4, B5 see R16
	assign altSel.pb[2] = fB[2] == `PFM_CODE_ALT1;
	assign altOut.pb[2] = lcdSeg[5];
	assign altOe.pb[2]  = 1'b1;
	assign altSel.pb[4] = fB[4] == `PFM_CODE_ALT1;
	assign altOut.pb[4] = lcdSeg[7];
	assign altOe.pb[4]  = 1'b1;
	assign altSel.pb[5] = fB[5] == `PFM_CODE_ALT1;
	assign altOut.pb[5] = lcdSeg[8];
	assign altOe.pb[5]  = 1'b1;
	// line B6 see R18
	assign altSel.pb[6] = fB[6] == `PFM_CODE_ALT1 | fB[6] == `PFM_CODE_ALT3;
	assign altOut.pb[6] = (fB[6] == `PFM_CODE_ALT1) & timerOut;
	assign altOe.pb[6]  = fB[6] == `PFM_CODE_ALT1;
	// line B7 see R17
	assign altSel.pb[7] = fB[7] == `PFM_CODE_ALT1 | fB[7] == `PFM_CODE_ALT3;
	assign altOut.pb[7] = (fB[7] == `PFM_CODE_ALT1) & serial.txOut;
	assign altOe.pb[7]  = (fB[7] == `PFM_CODE_ALT1) & serial.txOe;

	// lines C0 to C3 see R19; the rest of C and all of D stay gpio
	generate
		for (g = 0; g < 8; g++) begin : g_pc
			if (g < `PFM_COMS) begin : g_com
				assign altSel.pc[g] = fC[g] == `PFM_CODE_ALT1;
				assign altOut.pc[g] = lcdCom[g];
				assign altOe.pc[g]  = 1'b1;
			end else begin : g_plain
				assign altSel.pc[g] = 1'b0;
				assign altOut.pc[g] = 1'b0;
				assign altOe.pc[g]  = 1'b0;
			end
		end
	endgenerate
	assign altSel.pd = '0;
	assign altOut.pd = '0;
	assign altOe.pd  = '0;

	// ****************************************************************
	// pad drive: peripheral when selected, else gpio
	// ****************************************************************
	logic [`PFM_PADS-1:0] next_padOut;
	logic [`PFM_PADS-1:0] next_padOe;

	generate
		for (g = 0; g < `PFM_PADS; g++) begin : g_pad
			assign next_padOut[g] = altSel[g] ? altOut[g] : gpioOut[g]; // see R20
			assign next_padOe[g]  = altSel[g] ? altOe[g]
			                                  : ~gpioIsInput[g]; // see R20
		end
	endgenerate

	// ****************************************************************
	// peripheral inputs from the selected pad only
	// ****************************************************************
	pfm_periph_in_t next_periphIn;

	assign next_periphIn.chipSel = // see R1
		(srcCs == `PFM_CODE_ALT1) ? padSync.pc[7] :
		(srcCs == `PFM_CODE_ALT2) ? padSync.pb[0] : padSync.pa[3];
	assign next_periphIn.serClk = // see R2
		(srcClk == `PFM_CODE_GPIO) ? padSync.pa[1] :
		(srcClk == `PFM_CODE_ALT1) ? padSync.pc[6] :
		(srcClk == `PFM_CODE_ALT2) ? padSync.pa[6] : padSync.pd[2];
	assign next_periphIn.serData = // see R4
		(srcDat == `PFM_CODE_GPIO) ? padSync.pa[2] :
		(srcDat == `PFM_CODE_ALT1) ? padSync.pc[5] :
		(srcDat == `PFM_CODE_ALT2) ? padSync.pa[5] : padSync.pd[3];
	assign next_periphIn.extInterrupt1 = (srcInt1 == `PFM_CODE_ALT1) // see R6
		? padSync.pa[7] : padSync.pa[4];
	assign next_periphIn.extInterrupt0 = (srcInt0 == `PFM_CODE_ALT1) // see R7
		? padSync.pb[0] : padSync.pa[1];
	assign next_periphIn.stdCapIn = (srcStd == `PFM_CODE_ALT1)
		? padSync.pd[0] : padSync.pa[4];
	// timer inputs without a source field are gated by their pad mode
	assign next_periphIn.timerClkIn = padSync.pa[6] // see R21
		& (fA[6] == `PFM_CODE_GPIO);
	assign next_periphIn.timerCapIn = padSync.pa[5] // see R21
		& (fA[5] == `PFM_CODE_GPIO);

	// ****************************************************************
	// analog selections
	// ****************************************************************
	logic [`PFM_ANA-1:0] next_analogSel;

	assign next_analogSel[0] = fA[1] == `PFM_CODE_ALT3;
	assign next_analogSel[1] = 1'b0;
	assign next_analogSel[2] = fB[6] == `PFM_CODE_ALT3;
	assign next_analogSel[3] = fB[7] == `PFM_CODE_ALT3;
	assign next_analogSel[4] = fA[5] == `PFM_CODE_ALT3;
	assign next_analogSel[5] = fA[6] == `PFM_CODE_ALT3;
	assign next_analogSel[6] = fA[7] == `PFM_CODE_ALT3;
	assign next_analogSel[7] = fB[0] == `PFM_CODE_ALT3;

	// ****************************************************************
	// output registers
	// ****************************************************************
	// one register stage costs a cycle but keeps pads glitch free
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			padOut    <= '0;
			padOe     <= '0;
			periphIn  <= '0;
			analogSel <= '0;
			vrefSel   <= 1'b0;
		end else begin
			padOut    <= next_padOut;
			padOe     <= next_padOe;
			periphIn  <= next_periphIn;
			analogSel <= next_analogSel;
			vrefSel   <= altSel.pa[4];
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	chk_cs_source: assert property (@(posedge clock) disable iff (!rstn) // see R1
		srcCs == `PFM_CODE_ALT3 |=> periphIn.chipSel == $past(padSync.pa[3]))
		else $error("chip select not taken from line A3 on code 3");
	chk_clk_source: assert property (@(posedge clock) disable iff (!rstn) // see R2
		srcClk == `PFM_CODE_ALT3 |=> periphIn.serClk == $past(padSync.pd[2]))
		else $error("serial clock not taken from line D2");
	chk_clk_master: assert property (@(posedge clock) disable iff (!rstn) // see R3
		(fA[6] == `PFM_CODE_ALT2 && fA[1] == `PFM_CODE_ALT1 && sckDrive)
		|=> padOe.pa[6] && padOe.pa[1] && padOut.pa[6] == padOut.pa[1])
		else $error("master clock not driven on every clock pad");
	chk_data_source: assert property (@(posedge clock) disable iff (!rstn) // see R4
		srcDat == `PFM_CODE_ALT1 |=> periphIn.serData == $past(padSync.pc[5]))
		else $error("serial data not taken from line C5");
	chk_external_interrupt_1_source: assert property (@(posedge clock) disable iff (!rstn) // see R6
		srcInt1 == `PFM_CODE_ALT2
		|=> periphIn.extInterrupt1 == $past(padSync.pa[4]))
		else $error("interrupt 1 not taken from line A4");
	chk_external_interrupt_0_source: assert property (@(posedge clock) disable iff (!rstn) // see R7
		srcInt0 == `PFM_CODE_ALT1
		|=> periphIn.extInterrupt0 == $past(padSync.pb[0]))
		else $error("interrupt 0 not taken from line B0");
	chk_analog_release: assert property (@(posedge clock) disable iff (!rstn) // see R9
		fA[1] == `PFM_CODE_ALT3 |=> !padOe.pa[1] && analogSel[0])
		else $error("analog pad still driven");
	chk_gpio_default: assert property (@(posedge clock) disable iff (!rstn) // see R20
		fB[2] != `PFM_CODE_ALT1 |=> padOe.pb[2] == !$past(gpioIsInput.pb[2])
		&& padOut.pb[2] == $past(gpioOut.pb[2]))
		else $error("gpio does not own an unselected pad");
	chk_com_drive: assert property (@(posedge clock) disable iff (!rstn) // see R19
		fC[0] == `PFM_CODE_ALT1 |=> padOe.pc[0] && padOut.pc[0] == $past(lcdCom[0]))
		else $error("common driver not on line C0");
	chk_tx_line_a0: assert property ( // see R10
		@(posedge clock) disable iff (!rstn)
		fA[0] == `PFM_CODE_ALT1 |=> padOut.pa[0] == $past(serial.txOut)
		&& padOe.pa[0] == $past(serial.txOe))
		else $error("transmit output not on line A0");
	chk_data_line_a2: assert property ( // see R8
		@(posedge clock) disable iff (!rstn)
		fA[2] == `PFM_CODE_ALT1 |=> padOut.pa[2] == $past(serial.dataOut)
		&& padOe.pa[2] == $past(serial.dataOe))
		else $error("serial data not on line A2");
	chk_vref_claim: assert property ( // see R14
		@(posedge clock) disable iff (!rstn)
		fA[4] == `PFM_CODE_ALT2 |=> vrefSel && !padOe.pa[4])
		else $error("reference line A4 not claimed");
	chk_seg_line_b2: assert property ( // see R16
		@(posedge clock) disable iff (!rstn)
		fB[2] == `PFM_CODE_ALT1 |=> padOe.pb[2]
		&& padOut.pb[2] == $past(lcdSeg[5]))
		else $error("segment 5 not on line B2");
	chk_timer_b6: assert property ( // see R18
		@(posedge clock) disable iff (!rstn)
		fB[6] == `PFM_CODE_ALT1 |=> padOe.pb[6]
		&& padOut.pb[6] == $past(timerOut))
		else $error("timer output not on line B6");
	chk_analog_b7: assert property ( // see R17
		@(posedge clock) disable iff (!rstn)
		fB[7] == `PFM_CODE_ALT3 |=> analogSel[3] && !padOe.pb[7])
		else $error("analog line B7 still driven");
	chk_timer_gate: assert property ( // see R21
		@(posedge clock) disable iff (!rstn)
		fA[6] != `PFM_CODE_GPIO |=> !periphIn.timerClkIn)
		else $error("timer clock sees a claimed pad");

	cov_master_clk: cover property (@(posedge clock) disable iff (!rstn)
		sckDrive && fA[6] == `PFM_CODE_ALT2);
	cov_analog: cover property (@(posedge clock) disable iff (!rstn)
		analogSel != '0);
	cov_int_move: cover property (@(posedge clock) disable iff (!rstn)
		srcInt0 == `PFM_CODE_ALT1 ##1 srcInt0 == `PFM_CODE_GPIO);
	cov_seg_lines: cover property (@(posedge clock) disable iff (!rstn)
		fB[2] == `PFM_CODE_ALT1 && fB[4] == `PFM_CODE_ALT1);

endmodule

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
	import pfm_pkg::*;

	logic           clock;
	logic           rstn;
	logic           psel;
	logic           penable;
	logic           pwrite;
	logic [11:0]    paddr;
	logic [31:0]    pwdata;
	logic [3:0]     pstrb;
	logic [31:0]    prdata;
	logic           pready;
	logic           pslverr;
	pfm_port_t      padIn;
	pfm_port_t      gpioOut;
	pfm_port_t      gpioIsInput;
	logic           serEnable;
	logic           spiMaster;
	pfm_serial_t    serial;
	logic           timerOut;
	logic [8:0]     lcdSeg;
	logic [3:0]     lcdCom;
	pfm_port_t      padOut;
	pfm_port_t      padOe;
	pfm_periph_in_t periphIn;
	logic [7:0]     analogSel;
	logic           vrefSel;
	int             failCount;
	int             checks;
	int             seed;
	logic [32:0]    readQ[$];
	int             csTab[4]   = '{3, 23, 8, 3};
	int             clkTab[4]  = '{1, 22, 6, 26};
	int             datTab[4]  = '{2, 21, 5, 27};
	int             int1Tab[4] = '{4, 7, 4, 4};
	int             int0Tab[4] = '{1, 8, 1, 1};
	int             stdTab[4]  = '{4, 24, 4, 4};
	pfm_port_t      pads;

	pfm_pin_mux i_pfm_pin_mux (
		.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.padIn(padIn), .gpioOut(gpioOut), .gpioIsInput(gpioIsInput),
		.serEnable(serEnable), .spiMaster(spiMaster), .serial(serial),
		.timerOut(timerOut), .lcdSeg(lcdSeg), .lcdCom(lcdCom),
		.padOut(padOut), .padOe(padOe), .periphIn(periphIn),
		.analogSel(analogSel), .vrefSel(vrefSel)
	);

	// ****************************************************************
	// clock, checking and closing
	// ****************************************************************
	always #20 clock = ~clock;

	task automatic chk(input logic [32:0] got, input logic [32:0] exp,
		input string msg);
		checks++;
		if (got !== exp) begin
			failCount++;
			$display("Error %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks, failCount);
		if (failCount == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// read data is judged against the oldest note when the access completes
	always @(posedge clock) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (readQ.size() == 0) begin
				chk(33'h0, 33'h1, "unexpected read");
			end else begin
				chk({pslverr, prdata}, readQ.pop_front(), "apb read");
			end
		end
	end

	initial begin
		#(40 * 20000);
		failCount++;
		results();
	end

	// ****************************************************************
	// apb master
	// ****************************************************************
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			chk(33'h0, 33'h1, "pready timeout");
			results();
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [32:0] exp);
		readQ.push_back(exp);
		apb(1'b0, a, 32'h0);
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		clock = 0; rstn = 0; psel = 0; penable = 0; pwrite = 0;
		paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hf; seed = 64;
		padIn = $random(seed); gpioOut = $random(seed);
		gpioIsInput = $random(seed); serial = 7'($random(seed));
		timerOut = 1'($random(seed)); lcdSeg = 9'($random(seed));
		lcdCom = 4'($random(seed));
		serEnable = 1'b0; spiMaster = 1'b0; failCount = 0; checks = 0;
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		for (int i = 0; i < 7; i++) rd(12'(4 * i), 33'h0);
		rd(12'h01c, 33'h1_0000_0000);
		apb(1'b1, 12'h004, 32'h0000_00ff);
		rd(12'h004, 33'h0_0000_000f);
		apb(1'b1, 12'h008, 32'h0000_00a5);
		rd(12'h008, 33'h0_0000_00a5);
		pstrb <= 4'he;
		apb(1'b1, 12'h008, 32'h0000_005a);
		pstrb <= 4'hf;
		rd(12'h008, 33'h0_0000_00a5);
		$display("register test done");
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, 12'h000, {24'h0, 2'(c), 2'(c), 2'(c), 2'(c)});
			apb(1'b1, 12'h004, {28'h0, 2'(c), 2'(c)});
			pads = $random(seed);
			padIn <= pads;
			repeat (5) @(posedge clock);
			chk(periphIn.chipSel, pads[csTab[c]], "cs src");
			chk(periphIn.serClk, pads[clkTab[c]], "clk src");
			chk(periphIn.serData, pads[datTab[c]], "data src");
			chk(periphIn.extInterrupt1, pads[int1Tab[c]], "external_interrupt_1");
			chk(periphIn.extInterrupt0, pads[int0Tab[c]], "external_interrupt_0");
			chk(periphIn.stdCapIn, pads[stdTab[c]], "std cap src");
			chk({periphIn.timerClkIn, periphIn.timerCapIn},
				{pads[6], pads[5]}, "timer in");
		end
		$display("input source test done");
		apb(1'b1, 12'h008, 32'h0000_0009);
		apb(1'b1, 12'h00c, 32'h0000_0042);
		apb(1'b1, 12'h010, 32'h0000_0000);
		apb(1'b1, 12'h014, 32'h0000_00d0);
		apb(1'b1, 12'h018, 32'h0000_0055);
		repeat (2) @(posedge clock);
		chk({padOut.pa[0], padOe.pa[0]}, {serial.txOut, serial.txOe},
			"tx on a0");
		chk({padOut.pa[1], padOe.pa[1]}, {~timerOut, 1'b1},
			"timer inv a1");
		chk(vrefSel, 1'b1, "vref a4");
		chk({padOut.pa[7], padOe.pa[7]}, {lcdSeg[2], 1'b1},
			"seg2 a7");
		chk({padOut.pb[0], padOe.pb[0]},
			{gpioOut.pb[0], ~gpioIsInput.pb[0]}, "gpio b0");
		chk({padOut.pb[6], padOe.pb[6]}, {timerOut, 1'b1},
			"timer b6");
		chk(analogSel[3], 1'b1, "an3 b7");
		chk({padOut.pc[3:0], padOe.pc[3:0]}, {lcdCom, 4'hf},
			"commons");
		$display("pad function test done");
		apb(1'b1, 12'h008, 32'h0000_0004);
		apb(1'b1, 12'h00c, 32'h0000_0020);
		serEnable <= 1'b1;
		spiMaster <= 1'b1;
		repeat (3) @(posedge clock);
		chk({padOut.pa[1], padOe.pa[1], padOut.pa[6], padOe.pa[6]},
			{serial.serClkOut, 1'b1, serial.serClkOut, 1'b1},
			"spi clk out");
		chk(periphIn.timerClkIn, 1'b0, "timer clk gated");
		spiMaster <= 1'b0;
		repeat (3) @(posedge clock);
		chk({padOe.pa[1], padOe.pa[6]}, 2'b00,
			"clk slave input");
		$display("spi clock test done");
		apb(1'b1, 12'h008, 32'h0000_001c);
		apb(1'b1, 12'h010, 32'h0000_0013);
		apb(1'b1, 12'h014, 32'h0000_00d5);
		repeat (2) @(posedge clock);
		chk({analogSel[0], padOe.pa[1]}, 2'b10, "an0 a1");
		chk({padOut.pa[2], padOe.pa[2]}, {serial.dataOut, serial.dataOe},
			"data a2");
		chk({analogSel[7], padOe.pb[0]}, 2'b10, "an7 b0");
		chk({padOut.pb[2], padOut.pb[4], padOut.pb[5], padOe.pb[5:4],
			padOe.pb[2]}, {lcdSeg[5], lcdSeg[7], lcdSeg[8], 3'h7},
			"segs b");
		$display("analog and segment test done");
		repeat (3) @(posedge clock);
		results();
	end
endmodule
